// ---- src/tcl_pkg.sv ----
// constants and carrier types for the three-wire configuration load port
// assumes one system clock (mclk) and a host-driven serial clock with no reset of its own
// Function
// - every rising serial clock edge shifts the serial data level into the 24-bit shift register.
// - a rising load strobe copies the shift register into one of four configuration latches.
// - the destination latch comes from the latch-select bits in the two lowest word positions.
// - with chip enable low the device is powered down and the pump output is high impedance.
// - with chip enable high the device powers up only as far as the power-down bits allow.
// - the observe output shows lock detect, scaled RF or scaled reference as programmed.
// - latch select 00 is control, 01 is R counter, 10 is N counter and 11 is factory test.
package tcl_pkg;

    localparam int          TCL_WORD_W     = 24;
    localparam int          TCL_NUM_LATCH  = 4;
    localparam int          TCL_SEL_W      = 2;

    // latch select codes
    localparam logic [1:0]  TCL_SEL_CTRL   = 2'h0;
    localparam logic [1:0]  TCL_SEL_RCNT   = 2'h1;
    localparam logic [1:0]  TCL_SEL_NCNT   = 2'h2;
    localparam logic [1:0]  TCL_SEL_TEST   = 2'h3;

    // control latch field positions
    localparam int          TCL_PD2_BIT    = 21;
    localparam int          TCL_PD1_BIT    = 20;
    localparam int          TCL_CP3S_BIT   = 9;
    localparam int          TCL_MUX_LSB    = 5;
    localparam int          TCL_MUX_W      = 3;

    // observe source codes
    localparam logic [2:0]  TCL_MUX_LOCK   = 3'h1;
    localparam logic [2:0]  TCL_MUX_RF     = 3'h2;
    localparam logic [2:0]  TCL_MUX_REF    = 3'h4;

    localparam logic [23:0] TCL_LATCH_RST  = 24'h000000;

    typedef logic [TCL_WORD_W-1:0] tcl_word_type;

    typedef struct packed {
        tcl_word_type test_latch;
        tcl_word_type ncnt_latch;
        tcl_word_type rcnt_latch;
        tcl_word_type ctrl_latch;
    } tcl_cfg_type;

    typedef struct packed {
        logic powered;
        logic pump_oe;
        logic observe;
    } tcl_stat_type;

endpackage : tcl_pkg

// ---- src/tcl_sync3.sv ----
// three-stage pin synchroniser with agreed level and rising-edge pulse
// assumes the input is asynchronous to clk; rst is synchronous, active high
`timescale 1ns/1ps
module tcl_sync3 (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pin side
    input  wire logic pin,
    // synchronised side
    output logic      level,
    output logic      rise
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;
    wire  agree = (s2_r == s3_r);

    // only the second stage reads the first
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
        end else begin
            s1_r    <= pin;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            if (agree) begin
                level_r <= s3_r;
            end
        end
    end

    assign level = level_r;
    assign rise  = agree & s3_r & ~level_r;
endmodule : tcl_sync3

// ---- src/tcl_load_port.sv ----
// three-wire configuration load port: serial shifter, latch bank, power and observe control
// assumes serial clock is quiet while the load strobe is high, so the word is static when sampled
`timescale 1ns/1ps
module tcl_load_port
    import tcl_pkg::*;
#(
    parameter int WORD_W = TCL_WORD_W
) (
    // system clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // serial link pins
    input  wire logic         sclk,
    input  wire logic         sdata,
    input  wire logic         load_strobe,
    input  wire logic         chip_enable,
    // observation sources from the synthesizer core
    input  wire logic         lock_detect,
    input  wire logic         rf_scaled,
    input  wire logic         ref_scaled,
    // outputs
    output tcl_cfg_type       cfg,
    output logic [3:0]        latch_loaded,
    output logic              powered,
    output logic              pump_oe,
    output logic              observe_output_pin
);
    // serial domain: data only, so no reset is needed or available there
    logic [WORD_W-1:0] shift_r;

    always_ff @(posedge sclk) begin
        shift_r <= {shift_r[WORD_W-2:0], sdata};
    end

    // pin crossings into mclk
    logic strobe_lvl;
    logic strobe_rise;
    logic ce_lvl;

    tcl_sync3 u_strobe_sync (
        .clk   (mclk),
        .rst   (rst),
        .pin   (load_strobe),
        .level (strobe_lvl),
        .rise  (strobe_rise)
    );

    tcl_sync3 u_ce_sync (
        .clk   (mclk),
        .rst   (rst),
        .pin   (chip_enable),
        .level (ce_lvl),
        .rise  ()
    );

    // the strobe edge is the handshake: word is held still by the quiet serial clock
    wire [TCL_SEL_W-1:0] sel_bits = shift_r[TCL_SEL_W-1:0];

    // latch bank
    tcl_word_type latch_r [TCL_NUM_LATCH];
    logic [3:0]   loaded_r;

    genvar gi;
    generate
        for (gi = 0; gi < TCL_NUM_LATCH; gi++) begin : g_latch
            wire hit = strobe_rise & (sel_bits == TCL_SEL_W'(gi));
            always_ff @(posedge mclk) begin
                if (rst) begin
                    latch_r[gi]  <= TCL_LATCH_RST;
                    loaded_r[gi] <= 1'b0;
                end else begin
                    loaded_r[gi] <= hit;
                    if (hit) begin
                        latch_r[gi] <= shift_r;
                    end
                end
            end
        end
    endgenerate

    assign cfg.ctrl_latch = latch_r[TCL_SEL_CTRL];
    assign cfg.rcnt_latch = latch_r[TCL_SEL_RCNT];
    assign cfg.ncnt_latch = latch_r[TCL_SEL_NCNT];
    assign cfg.test_latch = latch_r[TCL_SEL_TEST];
    assign latch_loaded   = loaded_r;

    // power and pump control
    wire                 pd_any   = latch_r[TCL_SEL_CTRL][TCL_PD1_BIT] | latch_r[TCL_SEL_CTRL][TCL_PD2_BIT];
    wire                 cp_3s    = latch_r[TCL_SEL_CTRL][TCL_CP3S_BIT];
    wire [TCL_MUX_W-1:0] mux_sel  = latch_r[TCL_SEL_CTRL][TCL_MUX_LSB +: TCL_MUX_W];
    wire                 pwr_nxt  = ce_lvl & ~pd_any;
    wire                 oe_nxt   = pwr_nxt & ~cp_3s;

    wire obs_nxt = (mux_sel == TCL_MUX_LOCK) ? lock_detect :
                   (mux_sel == TCL_MUX_RF)   ? rf_scaled   :
                   (mux_sel == TCL_MUX_REF)  ? ref_scaled  : 1'b0;

    tcl_stat_type stat_r;
    tcl_stat_type stat_nxt;
    assign stat_nxt = '{powered: pwr_nxt, pump_oe: oe_nxt, observe: obs_nxt};

    always_ff @(posedge mclk) begin
        if (rst) begin
            stat_r <= '0;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    assign powered            = stat_r.powered;
    assign pump_oe            = stat_r.pump_oe;
    assign observe_output_pin = stat_r.observe;

    // strobe level is kept visible to no one; only the edge matters
    logic unused_lvl;
    assign unused_lvl = strobe_lvl;
endmodule : tcl_load_port

// ---- tb/tcl_chk.sv ----
// checker for latch, power and observe relations
// assumes it is bound to tcl_load_port
`timescale 1ns/1ps
module tcl_chk
    import tcl_pkg::*;
(
    // watched ports
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        chip_enable,
    input wire logic        lock_detect,
    input wire tcl_cfg_type cfg,
    input wire logic [3:0]  latch_loaded,
    input wire logic        powered,
    input wire logic        pump_oe,
    input wire logic        observe_output_pin
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_latch_hold: assert property (latch_loaded == 4'h0 |-> $stable(cfg)) else $error("latch moved");
    a_load_once: assert property (latch_loaded != 4'h0 |-> $onehot(latch_loaded) ##1 latch_loaded == 4'h0)
        else $error("load pulse");
    a_rcnt_sel: assert property (latch_loaded[1] |-> cfg.rcnt_latch[1:0] == TCL_SEL_RCNT) else $error("r sel");
    a_ncnt_sel: assert property (latch_loaded[2] |-> cfg.ncnt_latch[1:0] == TCL_SEL_NCNT) else $error("n sel");
    a_ce_off: assert property (!chip_enable [*6] |-> !powered && !pump_oe) else $error("ce off");
    a_pd_bits: assert property (powered |-> $past(cfg.ctrl_latch[21:20]) == 2'h0) else $error("pd");
    a_pump_tri: assert property (pump_oe |-> !$past(cfg.ctrl_latch[9])) else $error("pump");
    a_obs_lock: assert property ($past(cfg.ctrl_latch[7:5]) == TCL_MUX_LOCK |->
        observe_output_pin == $past(lock_detect))
        else $error("observe");
    c_ctrl: cover property (latch_loaded[0]);
    c_pwr: cover property (powered);
    c_pump: cover property (pump_oe);
endmodule : tcl_chk
bind tcl_load_port tcl_chk tcl_chk_inst (.mclk, .rst, .chip_enable, .lock_detect, .cfg, .latch_loaded,
    .powered, .pump_oe, .observe_output_pin);

// ---- tb/tcl_host.sv ----
// host model driving the three serial pins
// assumes one caller; the link clock runs only within a frame
`timescale 1ns/1ps
module tcl_host (
    // serial pins
    output logic sclk,
    output logic sdata,
    output logic load_strobe
);
    initial begin
        sclk = 1'b0;
        sdata = 1'b1;
        load_strobe = 1'b0;
    end
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            sdata = w[i];
            #12 sclk = 1'b1;
            #24 sclk = 1'b0;
            #12;
        end
        // released line shows no stale bit
        sdata = ~w[0];
        #60 load_strobe = 1'b1;
        #200 load_strobe = 1'b0;
        #100;
    endtask : send
endmodule : tcl_host

// ---- tb/tb.sv ----
// self-checking bench for the load port
// assumes the host model owns the serial pins
`timescale 1ns/1ps
module tb;
    import tcl_pkg::*;
    logic         mclk = 1'b0, rst = 1'b1, chip_enable = 1'b1;
    logic         lock_detect = 1'b0, rf_scaled = 1'b0, ref_scaled = 1'b0;
    logic         sclk, sdata, load_strobe, powered, pump_oe, observe_output_pin;
    logic [3:0]   latch_loaded;
    tcl_cfg_type  cfg;
    tcl_word_type exp [4] = '{default: '0};
    integer       seed = 32'h5cefd59c;
    int           n_errors = 0, num_checks = 0;
    always #10 mclk = ~mclk;
    tcl_host tcl_host_inst (.sclk, .sdata, .load_strobe);
    tcl_load_port tcl_load_port_inst (.mclk, .rst, .sclk, .sdata, .load_strobe, .chip_enable, .lock_detect,
        .rf_scaled, .ref_scaled, .cfg, .latch_loaded, .powered, .pump_oe, .observe_output_pin);
    function automatic logic pwr_exp(input logic ce);
        return ce && exp[0][TCL_PD2_BIT:TCL_PD1_BIT] == 2'h0;
    endfunction : pwr_exp
    function automatic logic obs_exp(input logic [2:0] src);
        return $onehot(exp[0][7:5]) && |(exp[0][7:5] & src);
    endfunction : obs_exp
    task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] want);
        num_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, want, seen);
        end
    endtask : chk
    task automatic load(input tcl_word_type w);
        tcl_host_inst.send(w);
        exp[w[1:0]] = w;
        chk("cfg", cfg, {exp[3], exp[2], exp[1], exp[0]}); // latch contents
    endtask : load
    task automatic stat(input logic ce);
        @(negedge mclk);
        chip_enable = ce;
        {ref_scaled, rf_scaled, lock_detect} = 3'($random(seed));
        repeat (8) @(negedge mclk);
        chk("powered", powered, pwr_exp(ce));
        chk("pump_oe", pump_oe, pwr_exp(ce) && !exp[0][TCL_CP3S_BIT]);
        chk("observe", observe_output_pin, obs_exp({ref_scaled, rf_scaled, lock_detect}));
    endtask : stat
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        logic [23:0] corner [5];
        tcl_word_type w;
        corner = '{24'h000020, 24'h000040, 24'h000080, 24'h000220, 24'h300020};
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        chk("reset", cfg, '0);
        // power-up order: R counter, control, N counter
        load({22'($random(seed)), TCL_SEL_RCNT});
        load(24'h000020);
        load({22'($random(seed)), TCL_SEL_NCNT});
        for (int k = 0; k < 5; k++) begin
            load(corner[k]);
            stat(1'b1);
        end
        for (int k = 0; k < 12; k++) begin
            w = 24'($random(seed));
            // host never writes the test latch
            if (w[1:0] == TCL_SEL_TEST) begin
                w[1] = 1'b0;
            end
            load(w);
            stat(1'($random(seed)));
        end
        stat(1'b0);
        wrap_up();
    end
endmodule : tb
